// ===== core/attr_access_map.svh
// Functional notes
// - offset register keeps six-bit attribute offset
// - each controller memory has thirteen port pages
// - page bit 4 picks first or second controller
// - page low nibble names port one to thirteen
// - write byte goes to memory on write command
// - write byte accepted even while device busy
// - overflow location: controller bit 4, port low nibble
// - attribute code names counter wrapped to zero
// - codes one to twelve name counted attributes
// - recorded overflow also raises overflow interrupt flag
// - matching identity with port above thirteen flagged
`ifndef ATTR_ACCESS_MAP_SVH
`define ATTR_ACCESS_MAP_SVH

// ==========================================================
// register offsets
`define OFS_ATTR_OFFSET   8'h20
`define OFS_PAGE_SELECT   8'h21
`define OFS_WRITE_BYTE    8'h22
`define OFS_FIRST_ID      8'h30
`define OFS_SECOND_ID     8'h31
`define OFS_OVF_LOCATION  8'h40
`define OFS_OVF_CODE      8'h41

// ==========================================================
// field positions and limits
`define CTRL_SEL_BIT      4
`define FIRST_PORT        4'h1
`define LAST_PORT         4'hD
`define LAST_PORT_WIDE    5'h0D
`define FIRST_ATTR_CODE   8'h01
`define LAST_ATTR_CODE    8'h0C

// ==========================================================
// reset values
`define RST_ATTR_OFFSET   6'h00
`define RST_PORT          4'h0
`define RST_WRITE_BYTE    8'h00
`define RST_ID            6'h00
`define RST_OVF_PORT      4'h0
`define RST_OVF_CODE      8'h3F

`endif

// ===== core/attr_access_pkg.sv
package attr_access_pkg;

  // ========================================================
  // pins and carriers
  typedef struct packed {
    logic       ale;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] ad;
  } cpu_pins_t;

  typedef struct packed {
    logic       ctrl;
    logic [3:0] port;
    logic [5:0] offset;
  } access_sel_t;

  typedef struct packed {
    logic        wr;
    logic        fill;
    logic [10:0] addr;
    logic [7:0]  data;
  } sram_req_t;

  typedef struct packed {
    logic       valid;
    logic       ctrl;
    logic [3:0] port;
    logic [7:0] code;
  } ovf_event_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] id;
    logic [4:0] port;
  } mgmt_status_t;

  typedef struct packed {
    logic prev;
  } edge_state_t;

endpackage

// ===== core/edge_pulse.sv
`timescale 1ns/1ps
module edge_pulse
  import attr_access_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic level,
  output logic      fall
);

  edge_state_t st_reg;
  edge_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.prev = level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fall = st_reg.prev & ~level;

endmodule

// ===== core/id_match.sv
`timescale 1ns/1ps
module id_match #(
  parameter int ID_W = 6
) (
  input  wire logic [ID_W-1:0] seen,
  input  wire logic [ID_W-1:0] held,
  output logic                 hit
);

  assign hit = (seen == held);

endmodule

// ===== core/attribute_access_registers.sv
`timescale 1ns/1ps
`include "attr_access_map.svh"
module attribute_access_registers
  import attr_access_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire cpu_pins_t    cpu,
  output logic [7:0]        ad_out,
  output logic              ad_oe,
  input  wire logic         wr_cmd,
  input  wire logic         fill_cmd,
  input  wire ovf_event_t   ovf_in,
  input  wire mgmt_status_t mgmt_in,
  output access_sel_t       sel,
  output logic              page_ok,
  output logic              write_pending,
  output sram_req_t         sram_req,
  output logic              overflow_interrupt_flag,
  output logic              bad_line_number_flag
);

  // ========================================================
  // state
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  ad_q;
    logic [5:0]  attribute_offset;
    logic        controller_select;
    logic [3:0]  port;
    logic [7:0]  write_byte;
    logic        wpend;
    logic [5:0]  first_controller_identity_value;
    logic [5:0]  second_controller_identity_value;
    logic        overflow_controller_flag;
    logic [3:0]  ovf_port;
    logic [7:0]  overflow_code;
    logic [7:0]  ad_out;
    logic        ad_oe;
    logic        page_ok;
    sram_req_t   req;
    logic        ovf_irq;
    logic        bad_port;
    mgmt_status_t mg;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  logic [1:0] rst_sync_reg;
  logic       srst_n;
  logic       wr_end;
  logic       hit_first;
  logic       hit_second;
  logic [3:0] page_idx;
  logic [7:0] rd_val;
  logic       rd_mapped;
  logic       wr_to_offset;
  logic       wr_to_page;
  logic       wr_to_byte;
  logic       wr_to_first;
  logic       wr_to_second;
  logic       ovf_accept;
  logic       id_known;
  logic       port_too_high;
  logic       port_in_range;
  logic [7:0] offset_byte;
  logic [7:0] page_byte;
  logic [7:0] first_id_byte;
  logic [7:0] second_id_byte;
  logic [7:0] location_byte;

  // ========================================================
  // reset release
  // the pin may rise anywhere in the cycle; two flops keep
  // the state flops from seeing a half-released reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign srst_n = rst_sync_reg[1];

  // ========================================================
  // helpers
  // data is taken from the cycle before strobe release, so
  // a slow data bus edge at release time cannot corrupt it
  edge_pulse u_wr_edge (
    .clk   (mclk),
    .rst_n (srst_n),
    .level (~cpu.cs_n & ~cpu.wr_n),
    .fall  (wr_end)
  );

  id_match #(.ID_W(6)) u_match_first (
    .seen (st_reg.mg.id),
    .held (st_reg.first_controller_identity_value),
    .hit  (hit_first)
  );

  id_match #(.ID_W(6)) u_match_second (
    .seen (st_reg.mg.id),
    .held (st_reg.second_controller_identity_value),
    .hit  (hit_second)
  );

  // port 0 wraps to page 15, ports 14 and 15 take pages 13 and 14; page_ok tells the user
  assign page_idx = st_reg.port - `FIRST_PORT;

  // ========================================================
  // write decode
  // ad_q holds the byte seen in the last strobe-low cycle
  assign wr_to_offset = wr_end & (st_reg.addr == `OFS_ATTR_OFFSET);
  assign wr_to_page   = wr_end & (st_reg.addr == `OFS_PAGE_SELECT);
  assign wr_to_byte   = wr_end & (st_reg.addr == `OFS_WRITE_BYTE);
  assign wr_to_first  = wr_end & (st_reg.addr == `OFS_FIRST_ID);
  assign wr_to_second = wr_end & (st_reg.addr == `OFS_SECOND_ID);

  // ========================================================
  // event qualifiers
  // ids reset to zero, so status from id 0 can flag early
  assign ovf_accept    = ovf_in.valid &&
                         (ovf_in.code >= `FIRST_ATTR_CODE) &&
                         (ovf_in.code <= `LAST_ATTR_CODE);
  assign id_known      = hit_first | hit_second;
  assign port_too_high = st_reg.mg.port > `LAST_PORT_WIDE;
  assign port_in_range = (st_reg.port >= `FIRST_PORT) &&
                         (st_reg.port <= `LAST_PORT);

  // ========================================================
  // read bytes, reserved bits forced low
  assign offset_byte    = {2'h0, st_reg.attribute_offset};
  assign page_byte      = {3'h0, st_reg.controller_select,
                           st_reg.port};
  assign first_id_byte  = {2'h0, st_reg.first_controller_identity_value};
  assign second_id_byte = {2'h0, st_reg.second_controller_identity_value};
  assign location_byte  = {3'h0, st_reg.overflow_controller_flag,
                           st_reg.ovf_port};

  // ========================================================
  // read mux
  always_comb begin
    rd_val    = 8'h00;
    rd_mapped = 1'b1;
    case (st_reg.addr)
      `OFS_ATTR_OFFSET: begin
        rd_val = offset_byte;
      end
      `OFS_PAGE_SELECT: begin
        rd_val = page_byte;
      end
      `OFS_WRITE_BYTE: begin
        rd_val = st_reg.write_byte;
      end
      `OFS_FIRST_ID: begin
        rd_val = first_id_byte;
      end
      `OFS_SECOND_ID: begin
        rd_val = second_id_byte;
      end
      `OFS_OVF_LOCATION: begin
        // reads have no side effects, so a stray strobe is harmless
        rd_val = location_byte;
      end
      `OFS_OVF_CODE: begin
        rd_val = st_reg.overflow_code;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  // ========================================================
  // next state
  always_comb begin
    st_next      = st_reg;
    st_next.ad_q = cpu.ad;
    if (cpu.ale) begin
      st_next.addr = cpu.ad;
    end

    // other register addresses belong to other blocks
    st_next.ad_oe  = ~cpu.cs_n & ~cpu.rd_n & rd_mapped;
    st_next.ad_out = rd_val;

    // writes elsewhere are ignored; the address latch stays free
    if (wr_to_offset) begin
      st_next.attribute_offset = st_reg.ad_q[5:0];
    end
    if (wr_to_page) begin
      st_next.controller_select = st_reg.ad_q[`CTRL_SEL_BIT];
      st_next.port              = st_reg.ad_q[3:0];
    end
    if (wr_to_byte) begin
      // never blocked by the sequencer being busy
      st_next.write_byte = st_reg.ad_q;
    end
    if (wr_to_first) begin
      st_next.first_controller_identity_value = st_reg.ad_q[5:0];
    end
    if (wr_to_second) begin
      st_next.second_controller_identity_value = st_reg.ad_q[5:0];
    end

    st_next.page_ok = port_in_range;

    // hand the held byte to the memory sequencer
    st_next.req.wr   = wr_cmd;
    st_next.req.fill = wr_cmd & fill_cmd;
    if (wr_cmd) begin
      st_next.req.data = st_reg.write_byte;
      st_next.req.addr = {st_reg.controller_select, page_idx,
                          st_reg.attribute_offset};
    end
    // a fresh write in the same cycle keeps the byte pending
    if (wr_to_byte) begin
      st_next.wpend = 1'b1;
    end else if (wr_cmd) begin
      st_next.wpend = 1'b0;
    end

    // overflow recording; codes outside the table are dropped
    // back to back events: the later one wins
    st_next.ovf_irq = 1'b0;
    if (ovf_accept) begin
      st_next.overflow_controller_flag = ovf_in.ctrl;
      st_next.ovf_port      = ovf_in.port;
      st_next.overflow_code = ovf_in.code;
      st_next.ovf_irq       = 1'b1;
    end

    // management status check, two cycles behind its input
    st_next.mg       = mgmt_in;
    st_next.bad_port = st_reg.mg.valid && id_known &&
                       port_too_high;
  end

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      st_reg.addr                             <= 8'h00;
      st_reg.ad_q                             <= 8'h00;
      st_reg.attribute_offset                 <= `RST_ATTR_OFFSET;
      st_reg.controller_select                <= 1'h0;
      st_reg.port                             <= `RST_PORT;
      st_reg.write_byte                       <= `RST_WRITE_BYTE;
      st_reg.wpend                            <= 1'h0;
      st_reg.first_controller_identity_value  <= `RST_ID;
      st_reg.second_controller_identity_value <= `RST_ID;
      st_reg.overflow_controller_flag         <= 1'h0;
      st_reg.ovf_port                         <= `RST_OVF_PORT;
      st_reg.overflow_code                    <= `RST_OVF_CODE;
      st_reg.ad_out                           <= 8'h00;
      st_reg.ad_oe                            <= 1'h0;
      st_reg.page_ok                          <= 1'h0;
      st_reg.req                              <= '0;
      st_reg.ovf_irq                          <= 1'h0;
      st_reg.bad_port                         <= 1'h0;
      st_reg.mg                               <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================
  // outputs
  assign ad_out                  = st_reg.ad_out;
  assign ad_oe                   = st_reg.ad_oe;
  assign sel                     = {st_reg.controller_select,
                                    st_reg.port,
                                    st_reg.attribute_offset};
  assign page_ok                 = st_reg.page_ok;
  assign write_pending           = st_reg.wpend;
  assign sram_req                = st_reg.req;
  assign overflow_interrupt_flag = st_reg.ovf_irq;
  assign bad_line_number_flag    = st_reg.bad_port;

endmodule

// ===== dv/attr_props.sv
`timescale 1ns/1ps
module attr_props
  import attr_access_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire cpu_pins_t    cpu,
  input wire logic [7:0]   ad_out,
  input wire logic         ad_oe,
  input wire logic         wr_cmd,
  input wire logic         fill_cmd,
  input wire ovf_event_t   ovf_in,
  input wire mgmt_status_t mgmt_in,
  input wire access_sel_t  sel,
  input wire logic         page_ok,
  input wire logic         write_pending,
  input wire sram_req_t    sram_req,
  input wire logic         overflow_interrupt_flag,
  input wire logic         bad_line_number_flag
);
  // ====================
  // port relations
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_page_ok;
    1 |=> page_ok == ($past(sel.port) inside {[4'h1:4'hD]});
  endproperty
  a_page_ok: assert property (p_page_ok) else $error("page_ok wrong");
  property p_wr;
    wr_cmd |=> sram_req.wr && sram_req.fill == $past(fill_cmd);
  endproperty
  a_wr: assert property (p_wr) else $error("no write pulse");
  property p_idle;
    !wr_cmd |=> !sram_req.wr && !sram_req.fill;
  endproperty
  a_idle: assert property (p_idle) else $error("stray write");
  property p_addr;
    wr_cmd |=> sram_req.addr ==
      {$past(sel.ctrl), $past(sel.port) - 4'h1, $past(sel.offset)};
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_ovf;
    ovf_in.valid && ovf_in.code inside {[8'h01:8'h0C]}
      |=> overflow_interrupt_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("flag missing");
  property p_ovf_bad;
    !(ovf_in.valid && ovf_in.code inside {[8'h01:8'h0C]})
      |=> !overflow_interrupt_flag;
  endproperty
  a_ovf_bad: assert property (p_ovf_bad) else $error("flag extra");
  property p_bad;
    bad_line_number_flag |->
      $past(mgmt_in.valid, 2) && $past(mgmt_in.port, 2) > 5'h0D;
  endproperty
  a_bad: assert property (p_bad) else $error("port flag extra");
  property p_oe;
    ad_oe |-> $past(cpu.cs_n) == 1'b0 && $past(cpu.rd_n) == 1'b0;
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven idle");
endmodule

// ===== dv/cpu_model.sv
`timescale 1ns/1ps
module cpu_model
  import attr_access_pkg::*;
(
  input wire logic       mclk,
  input wire logic [7:0] ad_out,
  input wire logic       ad_oe,
  output cpu_pins_t      cpu
);
  initial cpu = '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
  // ====================
  // byte cycle; released bus shows inverted last value, not a kind echo
  task automatic xfer(input logic rd, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    cpu <= '{1'b1, 1'b1, 1'b1, 1'b1, a};
    @(posedge mclk);
    cpu <= '{1'b0, 1'b0, !rd, rd, rd ? ~a : d};
    repeat (3) @(posedge mclk);
    q = ad_oe ? ad_out : 8'hXX;
    cpu <= '{1'b0, 1'b1, 1'b1, 1'b1, ~cpu.ad};
    repeat (2) @(posedge mclk);
  endtask
endmodule

// ===== dv/attribute_access_registers_bench.sv
`timescale 1ns/1ps
module attribute_access_registers_bench
  import attr_access_pkg::*;
;
  logic         mclk, rst_n, wr_cmd, fill_cmd, ad_oe, page_ok;
  logic         write_pending, overflow_interrupt_flag, bad_line_number_flag;
  logic [7:0]   ad_out, q, v, lo, off, d, loc, cd;
  logic [4:0]   p5;
  logic [31:0]  lfsr = 32'h00014BCA;
  cpu_pins_t    cpu;
  ovf_event_t   ovf_in;
  mgmt_status_t mgmt_in;
  access_sel_t  sel;
  sram_req_t    sram_req;
  int           n_fail, checks_done, i;
  logic [7:0]   ofs [5] = '{8'h20, 8'h21, 8'h22, 8'h30, 8'h31};
  logic [7:0]   msk [5] = '{8'h3F, 8'h1F, 8'hFF, 8'h3F, 8'h3F};
  logic [4:0]   pt [4] = '{5'h00, 5'h0D, 5'h0E, 5'h1F};

  attribute_access_registers i_attribute_access_registers (
    .mclk(mclk), .rst_n(rst_n), .cpu(cpu), .ad_out(ad_out), .ad_oe(ad_oe),
    .wr_cmd(wr_cmd), .fill_cmd(fill_cmd), .ovf_in(ovf_in),
    .mgmt_in(mgmt_in), .sel(sel), .page_ok(page_ok),
    .write_pending(write_pending), .sram_req(sram_req),
    .overflow_interrupt_flag(overflow_interrupt_flag),
    .bad_line_number_flag(bad_line_number_flag));
  cpu_model i_cpu_model (.mclk(mclk), .ad_out(ad_out), .ad_oe(ad_oe),
    .cpu(cpu));

  // ====================
  // helpers
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input logic [20:0] s, input logic [20:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    i_cpu_model.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] dv);
    i_cpu_model.xfer(1'b0, a, dv, q);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  // ====================
  // main sequence
  initial begin
    rst_n = 1'b0;
    wr_cmd = 1'b0;
    fill_cmd = 1'b0;
    ovf_in = '0;
    mgmt_in = '0;
    n_fail = 0;
    checks_done = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (i = 0; i < 5; i++)
      rdc(ofs[i], 8'h00);
    wrr(8'h40, 8'hFF);
    wrr(8'h41, 8'h00);
    rdc(8'h40, 8'h00);
    rdc(8'h41, 8'h3F);
    rdc(8'h50, 8'hXX);
    repeat (20) begin
      i = rnd() % 5;
      v = rnd();
      wrr(ofs[i], v);
      rdc(ofs[i], v & msk[i]);
    end
    $display("register test done");
    for (int p = 0; p < 16; p++) begin
      lo = rnd();
      v = {lo[7:4], p[3:0]};
      off = rnd();
      d = rnd();
      wrr(8'h21, v);
      wrr(8'h20, off);
      wrr(8'h22, d);
      wr_cmd <= 1'b1;
      fill_cmd <= lo[0];
      #1;
      chk(write_pending, 1'b1);
      chk(sel, {v[4:0], off[5:0]});
      chk(page_ok, p >= 1 && p <= 13);
      @(posedge mclk);
      wr_cmd <= 1'b0;
      #1;
      chk(sram_req, {2'b10 | lo[0], v[4], v[3:0] - 4'h1, off[5:0], d});
      chk(write_pending, 1'b0);
    end
    off = rnd();
    fork
      wrr(8'h22, off);
      begin
        repeat (5) @(posedge mclk);
        wr_cmd <= 1'b1;
        @(posedge mclk);
        wr_cmd <= 1'b0;
      end
    join
    #1;
    chk(write_pending, 1'b1);
    chk(sram_req.data, d);
    rdc(8'h22, off);
    $display("page test done");
    loc = 8'h00;
    cd = 8'h3F;
    for (int c = 0; c < 14; c++) begin
      lo = rnd();
      @(posedge mclk);
      ovf_in <= '{1'b1, lo[4], lo[3:0], c[7:0]};
      @(posedge mclk);
      ovf_in.valid <= 1'b0;
      #1;
      chk(overflow_interrupt_flag, c >= 1 && c <= 12);
      if (c >= 1 && c <= 12) begin
        loc = {3'b000, lo[4:0]};
        cd = c[7:0];
      end
      rdc(8'h40, loc);
      rdc(8'h41, cd);
    end
    $display("overflow test done");
    wrr(8'h30, 8'h15);
    wrr(8'h31, 8'h2A);
    for (int k = 0; k < 12; k++) begin
      lo = rnd();
      v = (k % 3 == 0) ? 8'h15 : (k % 3 == 1) ? 8'h2A : 8'h07;
      p5 = (k < 4) ? pt[k] : lo[4:0];
      @(posedge mclk);
      mgmt_in <= '{1'b1, v[5:0], p5};
      @(posedge mclk);
      mgmt_in.valid <= 1'b0;
      @(posedge mclk);
      #1;
      chk(bad_line_number_flag, k % 3 != 2 && p5 > 5'h0D);
    end
    $display("port number test done");
    give_verdict();
  end
endmodule

bind attribute_access_registers attr_props i_attr_props (
  .mclk(mclk), .rst_n(rst_n), .cpu(cpu), .ad_out(ad_out), .ad_oe(ad_oe),
  .wr_cmd(wr_cmd), .fill_cmd(fill_cmd), .ovf_in(ovf_in),
  .mgmt_in(mgmt_in), .sel(sel), .page_ok(page_ok),
  .write_pending(write_pending), .sram_req(sram_req),
  .overflow_interrupt_flag(overflow_interrupt_flag),
  .bad_line_number_flag(bad_line_number_flag));
